// >>> sbs_defines.svh
// constants shared by both ends of the synchronous burst static RAM bus
`ifndef SBS_DEFINES_SVH
`define SBS_DEFINES_SVH
`define SBS_ADDR_W 10
`define SBS_LANES 4
`define SBS_LANE_W 9
`define SBS_CNT_W 2
`define SBS_BURST_BEATS 2'h3
`define SBS_EXP_W 4
`define SBS_FLOW_SLOT 1
`define SBS_PIPE_SLOT 2
`define SBS_CLK_PERIOD_NS 4
`endif

// >>> sbs_pkg.sv
// types shared by both ends of the synchronous burst static RAM bus
package sbs_pkg;
    `include "sbs_defines.svh"

    typedef enum logic [1:0] {
        SBS_B_IDLE = 2'h1,
        SBS_B_ACTIVE = 2'h2
    } sbs_burst_state_t;

    typedef enum logic [2:0] {
        SBS_H_IDLE = 3'h1,
        SBS_H_ISSUE = 3'h2,
        SBS_H_SLEEP = 3'h4
    } sbs_host_state_t;
endpackage

// >>> sbs_bus_if.sv
// synchronous burst static RAM bus between controller and memory
`timescale 1ns/1ps
`include "sbs_defines.svh"
interface sbs_bus_if #(
    parameter int ADDR_W = `SBS_ADDR_W,
    parameter int LANES = `SBS_LANES,
    parameter int LANE_W = `SBS_LANE_W
) ();
    logic chip_select_primary_n;
    logic chip_select_secondary;
    logic chip_select_tertiary_n;
    logic processor_address_strobe_n;
    logic controller_address_strobe_n;
    logic burst_step_n;
    logic byte_write_enable_n;
    logic [LANES-1:0] byte_lane_select_n;
    logic all_bytes_write_n;
    logic output_enable_n;
    logic sleep_request;
    logic [ADDR_W-1:0] address;
    logic [LANES*LANE_W-1:0] host_dq_out;
    logic host_dq_oe;
    logic [LANES*LANE_W-1:0] dev_dq_out;
    logic dev_dq_oe;
    logic [LANES*LANE_W-1:0] dq;
    logic mode_drive;
    logic host_bypass_n;
    logic host_order_n;
    logic output_register_bypass_n;
    logic linear_order_select_n;

    // shared data wires; nobody driving reads as zero
    assign dq = host_dq_oe ? host_dq_out : (dev_dq_oe ? dev_dq_out : '0);
    // undriven mode pins are pulled high: interleaved order, pipelined output
    assign output_register_bypass_n = mode_drive ? host_bypass_n : 1'b1;
    assign linear_order_select_n = mode_drive ? host_order_n : 1'b1;

    modport device (
        input chip_select_primary_n, chip_select_secondary, chip_select_tertiary_n,
        input processor_address_strobe_n, controller_address_strobe_n, burst_step_n,
        input byte_write_enable_n, byte_lane_select_n, all_bytes_write_n,
        input output_enable_n, sleep_request, address, dq,
        input output_register_bypass_n, linear_order_select_n,
        output dev_dq_out, dev_dq_oe
    );

    modport host (
        output chip_select_primary_n, chip_select_secondary, chip_select_tertiary_n,
        output processor_address_strobe_n, controller_address_strobe_n, burst_step_n,
        output byte_write_enable_n, byte_lane_select_n, all_bytes_write_n,
        output output_enable_n, sleep_request, address,
        output host_dq_out, host_dq_oe, mode_drive, host_bypass_n, host_order_n,
        input dq
    );
endinterface

// >>> sbs_memory.sv
// memory end of the synchronous burst static RAM bus
`timescale 1ns/1ps
`include "sbs_defines.svh"
// How it works
// - all bus inputs except output enable sampled on rising clock
// - output enable and sleep act asynchronously
// - either address strobe starts a burst
// - later burst addresses stepped internally
// - counter spans two low address bits
// - order select low linear, high interleaved
// - fresh address accepted every cycle
// - bypass low gives flow-through read data
// - bypass high adds output register stage
// - deselects travel the read pipeline depth
// - outputs held, released after second edge when pipelined, after first when flow-through
// - byte write writes selected lanes only
// - all-bytes write writes every lane
// - sleep on request, data retained
// - floating modes mean interleaved, pipelined
// - write timing is internal, clocked only
// - two low address bits preset counter
// - burst step is active low
// - selected when primary, tertiary low, secondary high
module sbs_memory #(
    parameter int ADDR_W = `SBS_ADDR_W,
    parameter int LANES = `SBS_LANES,
    parameter int LANE_W = `SBS_LANE_W
) (
    input wire logic clock,
    input wire logic reset_n,
    sbs_bus_if.device bus,
    output logic sleeping,
    output logic burst_active,
    output logic pipelined_mode
);
    import sbs_pkg::*;

    localparam int W = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;

    typedef struct packed {
        sbs_burst_state_t burst;
        logic [ADDR_W-1:0] base;
        logic [`SBS_CNT_W-1:0] count;
        logic rd1;
        logic rd2;
        logic [W-1:0] data1;
        logic [W-1:0] data2;
        logic drive;
        logic [W-1:0] dq;
        logic sleeping;
        logic pipe;
    } sbs_mem_state_t;

    sbs_mem_state_t s_q;
    sbs_mem_state_t s_d;

    // array holds no reset: contents survive reset and sleep alike
    logic [W-1:0] mem [0:DEPTH-1];

    logic selected;
    logic strobe;
    logic start;
    logic cont;
    logic step;
    logic write_req;
    logic rd;
    logic wr;
    logic awake;
    logic [`SBS_CNT_W-1:0] low;
    logic [`SBS_CNT_W-1:0] count_step;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lane_en;
    logic [W-1:0] read_word;
    logic [W-1:0] write_word;

    // all three chip selects must agree
    assign selected = ~bus.chip_select_primary_n & bus.chip_select_secondary
        & ~bus.chip_select_tertiary_n;
    // processor strobe is ignored while the primary select is high
    assign strobe = ~bus.controller_address_strobe_n
        | (~bus.processor_address_strobe_n & ~bus.chip_select_primary_n);
    assign awake = ~bus.sleep_request;
    assign start = strobe & selected;
    assign cont = ~strobe & (s_q.burst == SBS_B_ACTIVE);
    assign step = cont & ~bus.burst_step_n;
    assign count_step = s_q.count + 2'h1;

    // interleave when order select is high, which is also the pulled default
    always_comb begin
        if (bus.linear_order_select_n) begin
            low = s_q.base[`SBS_CNT_W-1:0] ^ (step ? count_step : s_q.count);
        end else begin
            low = s_q.base[`SBS_CNT_W-1:0] + (step ? count_step : s_q.count);
        end
    end

    // low bits wrap inside the aligned group of four
    assign addr = start ? bus.address : {s_q.base[ADDR_W-1:`SBS_CNT_W], low};

    // processor-strobe starts are always reads; writes follow on later cycles
    assign write_req = ~bus.all_bytes_write_n
        | (~bus.byte_write_enable_n & ~(&bus.byte_lane_select_n));
    assign rd = awake & (start | cont) & ~(write_req & bus.processor_address_strobe_n);
    assign wr = awake & (start | cont) & write_req & bus.processor_address_strobe_n;

    assign read_word = mem[addr];

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            // all-bytes write overrides the lane selects
            assign lane_en[g] = ~bus.all_bytes_write_n
                | (~bus.byte_write_enable_n & ~bus.byte_lane_select_n[g]);
            assign write_word[g*LANE_W +: LANE_W] = lane_en[g]
                ? bus.dq[g*LANE_W +: LANE_W] : read_word[g*LANE_W +: LANE_W];
        end
    endgenerate

    // single clocked write; no pulse width asked of the host
    always_ff @(posedge clock) begin
        if (wr) begin
            mem[addr] <= write_word;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.pipe = bus.output_register_bypass_n;
        s_d.sleeping = bus.sleep_request;
        if (awake) begin
            case (s_q.burst)
                SBS_B_IDLE: begin
                    if (start) begin
                        s_d.burst = SBS_B_ACTIVE;
                    end
                end
                SBS_B_ACTIVE: begin
                    if (strobe & ~selected) begin
                        s_d.burst = SBS_B_IDLE;
                    end
                end
                default: begin
                    s_d.burst = SBS_B_IDLE;
                end
            endcase
            if (start) begin
                s_d.base = bus.address;
                s_d.count = '0;
            end else if (step) begin
                s_d.count = count_step;
            end
        end
        // first stage: array data straight after the sampling edge
        s_d.rd1 = rd;
        if (rd) begin
            s_d.data1 = read_word;
        end
        // second stage: output register of pipelined mode
        s_d.rd2 = s_q.rd1;
        s_d.data2 = s_q.data1;
        // deselects and writes ride the same stage as reads
        if (bus.output_register_bypass_n) begin
            s_d.drive = s_d.rd2;
            s_d.dq = s_d.rd2 ? s_d.data2 : s_q.dq;
        end else begin
            s_d.drive = s_d.rd1;
            s_d.dq = s_d.rd1 ? s_d.data1 : s_q.dq;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_q.burst <= SBS_B_IDLE;
            s_q.base <= '0;
            s_q.count <= '0;
            s_q.rd1 <= 1'b0;
            s_q.rd2 <= 1'b0;
            s_q.data1 <= '0;
            s_q.data2 <= '0;
            s_q.drive <= 1'b0;
            s_q.dq <= '0;
            s_q.sleeping <= 1'b0;
            s_q.pipe <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.dev_dq_out = s_q.dq;
    // output enable and sleep gate the drivers without the clock
    assign bus.dev_dq_oe = s_q.drive & ~bus.output_enable_n & ~bus.sleep_request;
    assign sleeping = s_q.sleeping;
    assign burst_active = (s_q.burst == SBS_B_ACTIVE);
    assign pipelined_mode = s_q.pipe;
endmodule

// >>> sbs_controller.sv
// controller end of the synchronous burst static RAM bus
`timescale 1ns/1ps
`include "sbs_defines.svh"
module sbs_controller #(
    parameter int ADDR_W = `SBS_ADDR_W,
    parameter int LANES = `SBS_LANES,
    parameter int LANE_W = `SBS_LANE_W,
    parameter bit PIPELINED = 1'b1,
    parameter bit INTERLEAVED = 1'b1,
    parameter bit DRIVE_MODES = 1'b0
) (
    input wire logic clock,
    input wire logic reset_n,
    sbs_bus_if.host bus,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_burst,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [LANES*LANE_W-1:0] req_wdata,
    input wire logic [LANES-1:0] req_lanes,
    input wire logic req_all_lanes,
    input wire logic sleep_in,
    output logic req_ready,
    output logic rsp_valid,
    output logic [LANES*LANE_W-1:0] rsp_data
);
    import sbs_pkg::*;

    localparam int W = LANES * LANE_W;

    typedef struct packed {
        sbs_host_state_t state;
        logic select;
        logic [ADDR_W-1:0] addr;
        logic strobe_n;
        logic step_n;
        logic all_n;
        logic bw_n;
        logic [LANES-1:0] lanes_n;
        logic [W-1:0] dout;
        logic doe;
        logic [1:0] beats;
        logic [`SBS_EXP_W-1:0] exp;
        logic ready;
        logic rsp_valid;
        logic [W-1:0] rsp_data;
        logic sleep;
        logic oe_n;
    } sbs_ctl_state_t;

    sbs_ctl_state_t s_q;
    sbs_ctl_state_t s_d;
    logic take;
    logic capture;

    assign take = req_valid & s_q.ready;
    // read data lands one edge later in pipelined mode
    assign capture = PIPELINED ? s_q.exp[`SBS_PIPE_SLOT] : s_q.exp[`SBS_FLOW_SLOT];

    always_comb begin
        s_d = s_q;
        s_d.select = 1'b0;
        // idle cycles are deselects, else the memory keeps reading and driving
        s_d.strobe_n = 1'b0;
        s_d.step_n = 1'b1;
        s_d.all_n = 1'b1;
        s_d.bw_n = 1'b1;
        s_d.lanes_n = '1;
        s_d.doe = 1'b0;
        s_d.exp = {s_q.exp[`SBS_EXP_W-2:0], 1'b0};
        s_d.rsp_valid = capture;
        if (capture) begin
            s_d.rsp_data = bus.dq;
        end
        s_d.sleep = sleep_in;
        case (s_q.state)
            SBS_H_IDLE: begin
                if (sleep_in) begin
                    s_d.state = SBS_H_SLEEP;
                end else if (take) begin
                    s_d.select = 1'b1;
                    s_d.strobe_n = 1'b0;
                    s_d.addr = req_addr;
                    if (req_write) begin
                        s_d.all_n = ~req_all_lanes;
                        s_d.bw_n = 1'b0;
                        s_d.lanes_n = ~req_lanes;
                        s_d.dout = req_wdata;
                        s_d.doe = 1'b1;
                    end else begin
                        s_d.exp[0] = 1'b1;
                        if (req_burst) begin
                            s_d.beats = `SBS_BURST_BEATS;
                            s_d.state = SBS_H_ISSUE;
                        end
                    end
                end
            end
            SBS_H_ISSUE: begin
                s_d.strobe_n = 1'b1;
                s_d.step_n = 1'b0;
                s_d.exp[0] = 1'b1;
                s_d.beats = s_q.beats - 2'h1;
                if (s_q.beats == 2'h1) begin
                    s_d.state = SBS_H_IDLE;
                end
            end
            SBS_H_SLEEP: begin
                if (!sleep_in) begin
                    s_d.state = SBS_H_IDLE;
                end
            end
            default: begin
                s_d.state = SBS_H_IDLE;
            end
        endcase
        // writes may follow back to back; reads drain before the bus turns
        s_d.ready = (s_d.state == SBS_H_IDLE) & ~(|s_d.exp) & ~sleep_in;
        // memory outputs enabled only while read data is awaited
        s_d.oe_n = ~(|s_d.exp);
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_q.state <= SBS_H_IDLE;
            s_q.select <= 1'b0;
            s_q.addr <= '0;
            s_q.strobe_n <= 1'b1;
            s_q.step_n <= 1'b1;
            s_q.all_n <= 1'b1;
            s_q.bw_n <= 1'b1;
            s_q.lanes_n <= '1;
            s_q.dout <= '0;
            s_q.doe <= 1'b0;
            s_q.beats <= '0;
            s_q.exp <= '0;
            s_q.ready <= 1'b0;
            s_q.rsp_valid <= 1'b0;
            s_q.rsp_data <= '0;
            s_q.sleep <= 1'b0;
            s_q.oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.chip_select_primary_n = ~s_q.select;
    assign bus.chip_select_secondary = s_q.select;
    assign bus.chip_select_tertiary_n = ~s_q.select;
    assign bus.processor_address_strobe_n = 1'b1;
    assign bus.controller_address_strobe_n = s_q.strobe_n;
    assign bus.burst_step_n = s_q.step_n;
    assign bus.byte_write_enable_n = s_q.bw_n;
    assign bus.byte_lane_select_n = s_q.lanes_n;
    assign bus.all_bytes_write_n = s_q.all_n;
    assign bus.output_enable_n = s_q.oe_n;
    assign bus.sleep_request = s_q.sleep;
    assign bus.address = s_q.addr;
    assign bus.host_dq_out = s_q.dout;
    assign bus.host_dq_oe = s_q.doe;
    // leaving modes undriven selects interleaved pipelined operation
    assign bus.mode_drive = DRIVE_MODES;
    assign bus.host_bypass_n = PIPELINED;
    assign bus.host_order_n = INTERLEAVED;
    assign req_ready = s_q.ready;
    assign rsp_valid = s_q.rsp_valid;
    assign rsp_data = s_q.rsp_data;
endmodule

// >>> sbs_bus_assertions.sv
// concurrent checks on the bus between controller and memory
`timescale 1ns/1ps
module sbs_bus_assertions #(
    parameter int LANES = 4
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic chip_select_primary_n,
    input wire logic chip_select_secondary,
    input wire logic chip_select_tertiary_n,
    input wire logic processor_address_strobe_n,
    input wire logic controller_address_strobe_n,
    input wire logic burst_step_n,
    input wire logic byte_write_enable_n,
    input wire logic [LANES-1:0] byte_lane_select_n,
    input wire logic all_bytes_write_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic host_dq_oe,
    input wire logic dev_dq_oe,
    input wire logic output_register_bypass_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    wire sel = !chip_select_primary_n && chip_select_secondary && !chip_select_tertiary_n;
    wire rd_start = sel && !controller_address_strobe_n && all_bytes_write_n && byte_write_enable_n;
    wire step = controller_address_strobe_n && processor_address_strobe_n && !burst_step_n;
    wire dsel = !controller_address_strobe_n && !sel;
    wire pipe_rd = rd_start && output_register_bypass_n;
    sequence burst_rd;
        pipe_rd ##1 step [*3];
    endsequence

    AST_OE_SLEEP: assert property (sleep_request |-> !dev_dq_oe)
        else $error("memory drives data while asleep");
    AST_OE_GATE: assert property (output_enable_n |-> !dev_dq_oe)
        else $error("memory drives data with output enable off");
    AST_NO_CLASH: assert property (!(host_dq_oe && dev_dq_oe))
        else $error("both ends drive the data bus");
    AST_WRITE_FORM: assert property (host_dq_oe |-> sel && !controller_address_strobe_n
        && (!all_bytes_write_n || (!byte_write_enable_n && byte_lane_select_n != '1)))
        else $error("write data without a write command");
    AST_PIPE_FIRST: assert property (pipe_rd |-> ##2 dev_dq_oe)
        else $error("pipelined read data not driven two edges on");
    AST_PIPE_NOT_EARLY: assert property (pipe_rd && !dev_dq_oe |=> !dev_dq_oe)
        else $error("pipelined read data driven one edge early");
    AST_PIPE_BURST: assert property (burst_rd |-> dev_dq_oe [*3])
        else $error("burst read data not driven for every beat");
    AST_DESELECT_HOLD: assert property (pipe_rd ##1 dsel |-> ##1 dev_dq_oe ##1 !dev_dq_oe)
        else $error("deselect did not release the bus at read depth");

    cover property (pipe_rd);
    cover property (burst_rd);
    cover property (host_dq_oe && !all_bytes_write_n);
    cover property (sleep_request);
endmodule

// >>> tb.sv
// self-checking bench: two controller and memory pairs in opposite modes
`timescale 1ns/1ps
module tb;
    import sbs_pkg::*;
    localparam int AW = 6;
    localparam int W = 36;
    logic clock;
    logic reset_n;
    logic [1:0] req_valid, req_write, req_burst, req_all, sleep_in;
    logic [1:0] req_ready, rsp_valid, sleeping, burst_active, pipelined_mode, dev_oe;
    logic [AW-1:0] req_addr [2];
    logic [W-1:0] req_wdata [2];
    logic [W-1:0] rsp_data [2];
    logic [3:0] req_lanes [2];
    logic [W-1:0] model [2][64];
    int bad_count = 0;
    int n_tests = 0;

    for (genvar g = 0; g < 2; g++) begin : g_pair
        sbs_bus_if #(.ADDR_W(AW)) u_sbs_bus_if ();
        sbs_memory #(.ADDR_W(AW)) u_sbs_memory (.clock(clock), .reset_n(reset_n),
            .bus(u_sbs_bus_if.device), .sleeping(sleeping[g]), .burst_active(burst_active[g]),
            .pipelined_mode(pipelined_mode[g]));
        sbs_controller #(.ADDR_W(AW), .PIPELINED(g == 0), .INTERLEAVED(g == 0),
            .DRIVE_MODES(g == 1)) u_sbs_controller (.clock(clock), .reset_n(reset_n),
            .bus(u_sbs_bus_if.host), .req_valid(req_valid[g]), .req_write(req_write[g]),
            .req_burst(req_burst[g]), .req_addr(req_addr[g]), .req_wdata(req_wdata[g]),
            .req_lanes(req_lanes[g]), .req_all_lanes(req_all[g]), .sleep_in(sleep_in[g]),
            .req_ready(req_ready[g]), .rsp_valid(rsp_valid[g]), .rsp_data(rsp_data[g]));
        assign dev_oe[g] = u_sbs_bus_if.dev_dq_oe;
        if (g == 0) begin : g_chk
            sbs_bus_assertions u_sbs_bus_assertions (.clock(clock), .reset_n(reset_n),
                .chip_select_primary_n(u_sbs_bus_if.chip_select_primary_n),
                .chip_select_secondary(u_sbs_bus_if.chip_select_secondary),
                .chip_select_tertiary_n(u_sbs_bus_if.chip_select_tertiary_n),
                .processor_address_strobe_n(u_sbs_bus_if.processor_address_strobe_n),
                .controller_address_strobe_n(u_sbs_bus_if.controller_address_strobe_n),
                .burst_step_n(u_sbs_bus_if.burst_step_n),
                .byte_write_enable_n(u_sbs_bus_if.byte_write_enable_n),
                .byte_lane_select_n(u_sbs_bus_if.byte_lane_select_n),
                .all_bytes_write_n(u_sbs_bus_if.all_bytes_write_n),
                .output_enable_n(u_sbs_bus_if.output_enable_n),
                .sleep_request(u_sbs_bus_if.sleep_request),
                .host_dq_oe(u_sbs_bus_if.host_dq_oe), .dev_dq_oe(u_sbs_bus_if.dev_dq_oe),
                .output_register_bypass_n(u_sbs_bus_if.output_register_bypass_n));
        end
    end

    task automatic check_val(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    // request held from one rising edge until the edge that sees ready high
    task automatic issue(input int p, input logic wr, input logic bu, input logic [AW-1:0] a,
        input logic [W-1:0] d, input logic [3:0] ln, input logic al);
        int k;
        k = 0;
        @(posedge clock);
        req_valid[p] <= 1'b1;
        req_write[p] <= wr;
        req_burst[p] <= bu;
        req_addr[p] <= a;
        req_wdata[p] <= d;
        req_lanes[p] <= ln;
        req_all[p] <= al;
        @(negedge clock);
        while (req_ready[p] !== 1'b1 && k < 100) begin
            @(negedge clock);
            k++;
        end
        @(posedge clock);
        req_valid[p] <= 1'b0;
    endtask

    task automatic wr(input int p, input logic [AW-1:0] a, input logic [W-1:0] d,
        input logic [3:0] ln, input logic al);
        issue(p, 1'b1, 1'b0, a, d, ln, al);
        for (int l = 0; l < 4; l++) begin
            if (al || ln[l]) model[p][a][l*9 +: 9] = d[l*9 +: 9];
        end
    endtask

    // pair 0 runs pipelined and interleaved, pair 1 flow-through and linear
    task automatic rd(input int p, input logic bu, input logic [AW-1:0] a);
        int n;
        logic [AW-1:0] ea;
        issue(p, 1'b0, bu, a, '0, 4'h0, 1'b0);
        n = 1;
        @(negedge clock);
        while (rsp_valid[p] !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        // counted from the take edge: flow answers at the third negedge, pipelined one later
        check_val("read latency", W'(p == 0 ? 4 : 3), W'(n));
        for (int i = 0; i < (bu ? 4 : 1); i++) begin
            if (i > 0) @(negedge clock);
            ea = p == 0 ? a ^ AW'(i) : {a[AW-1:2], a[1:0] + 2'(i)};
            check_val("read valid", W'(1), W'(rsp_valid[p]));
            check_val("read data", model[p][ea], rsp_data[p]);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // whole run needs well under a thousand cycles per pair
    initial begin
        #40000;
        bad_count++;
        final_report();
    end

    initial begin
        int k;
        reset_n = 1'b0;
        {req_valid, req_write, req_burst, req_all, sleep_in} = '0;
        req_addr = '{default: '0};
        req_wdata = '{default: '0};
        req_lanes = '{default: '0};
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            for (int a = 0; a < 8; a++) begin
                wr(p, AW'(a), 36'h9A5C3E17B + 36'h0F1E2D * a, 4'h0, 1'b1);
            end
            check_val("pipelined flag", W'(p == 0), W'(pipelined_mode[p]));
            wr(p, 6'h02, 36'hFFFFFFFFF, 4'h5, 1'b0);
            for (int a = 0; a < 8; a++) begin
                rd(p, 1'b0, AW'(a));
            end
            rd(p, 1'b1, 6'h05);
            rd(p, 1'b1, 6'h02);
            $display("burst and write test done for pair %0d", p);
            @(posedge clock);
            sleep_in[p] <= 1'b1;
            k = 0;
            @(negedge clock);
            while (sleeping[p] !== 1'b1 && k < 20) begin
                @(negedge clock);
                k++;
            end
            check_val("sleeping", W'(1), W'(sleeping[p]));
            check_val("data drive in sleep", W'(0), W'(dev_oe[p]));
            @(posedge clock);
            sleep_in[p] <= 1'b0;
            rd(p, 1'b0, 6'h02);
            rd(p, 1'b0, 6'h07);
            $display("sleep test done for pair %0d", p);
        end
        final_report();
    end
endmodule
